// ===== logic/flash_host_pkg.sv
// Summary of operation
// R1: Device reads array right after power-up; host may read without commands.
// R2: Chip select high makes device ignore all pins; host idles it high.
// R3: Address lines carry cell address on reads, command address on writes.
// R4: Data lines give the stored byte on reads, the command byte on writes.
// R5: Top map: boot 16K, two 8K parameter, 32K main at top; three 64K below.
// R6: Bottom map: boot 16K, two 8K parameter, 32K main from zero; 64K above.
// R7: Blocks erase alone and carry own protection against program and erase.
// R8: Hardware reset needs reset pin low for at least the minimum pulse time.
// R9: After reset release wait the longer recovery time before any bus cycle.
// R10: High voltage on reset pin unprotects all blocks while it is held.
// R11: Variant without reset pin has neither hardware reset nor unprotect.
// R12: Below supply lockout the device ignores every bus write.
// R13: Supply loss during program or erase aborts it; data left undefined.
// R14: Delivered array reads all ones.
// R15: Program and erase run by the internal controller once commanded.
// R16: Device reports completion and errors of program and erase.
// R17: Address latched at last falling strobe, data at first rising strobe.
// R18: Read: address, chip select and output enable low, write strobe high.
// R19: Output enable stays high throughout every bus write.
// R20: Invalid write sequence returns the device to read mode.
// R21: Top or bottom boot map is a build-time choice for block decoding.
package flash_host_pkg;
   localparam int          ADDR_W     = 18;
   localparam int          DATA_W     = 8;
   localparam int          CLK_NS     = 4;
   localparam int          NUM_BLOCKS = 7;
   localparam int          BLK_W      = 3;
   localparam bit          BOOT_TOP   = 1'b1;

   // Block start addresses, ascending; block index is the position here
   localparam logic [ADDR_W-1:0] TOP_START [NUM_BLOCKS] = '{
      18'h00000, 18'h10000, 18'h20000, 18'h30000,
      18'h38000, 18'h3A000, 18'h3C000};
   localparam logic [ADDR_W-1:0] BOT_START [NUM_BLOCKS] = '{
      18'h00000, 18'h04000, 18'h06000, 18'h08000,
      18'h10000, 18'h20000, 18'h30000};

   // Default bus timings in ns
   localparam int T_AS_NS      = 10;
   localparam int T_WP_NS      = 40;
   localparam int T_DH_NS      = 10;
   localparam int T_RD_NS      = 120;
   localparam int T_GAP_NS     = 30;
   localparam int T_RST_LOW_NS = 500;
   localparam int T_REC_SEL_NS = 50;
   localparam int T_REC_RDY_NS = 1000;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
      ST_GAP, ST_RST_LOW, ST_RST_REC
   } state_t;

   // Least time rounded up, never below one cycle
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic logic [BLK_W-1:0] block_of(input logic [ADDR_W-1:0] a,
                                                 input bit top);
      logic [BLK_W-1:0] idx;
      idx = '0;
      for (int i = 0; i < NUM_BLOCKS; i++) begin
         if (a >= (top ? TOP_START[i] : BOT_START[i])) begin
            idx = BLK_W'(i);
         end
      end
      return idx;
   endfunction
endpackage

// ===== logic/flash_host.sv
module flash_host
   import flash_host_pkg::*;
#(
   parameter bit HAS_RESET_PIN = 1'b1,
   parameter bit TOP_BOOT      = flash_host_pkg::BOOT_TOP,
   parameter int AS_NS         = flash_host_pkg::T_AS_NS,
   parameter int WP_NS         = flash_host_pkg::T_WP_NS,
   parameter int DH_NS         = flash_host_pkg::T_DH_NS,
   parameter int RD_NS         = flash_host_pkg::T_RD_NS,
   parameter int GAP_NS        = flash_host_pkg::T_GAP_NS,
   parameter int RST_LOW_NS    = flash_host_pkg::T_RST_LOW_NS,
   parameter int REC_SEL_NS    = flash_host_pkg::T_REC_SEL_NS,
   parameter int REC_RDY_NS    = flash_host_pkg::T_REC_RDY_NS
) (
   input  wire logic                               clk,
   input  wire logic                               rst_n,
   // User side
   input  wire logic                               req_valid,
   output logic                                    req_ready,
   input  wire logic                               req_write,
   input  wire logic [flash_host_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [flash_host_pkg::DATA_W-1:0]  req_wdata,
   output logic                                    rsp_valid,
   output logic [flash_host_pkg::DATA_W-1:0]       rsp_rdata,
   output logic [flash_host_pkg::BLK_W-1:0]        rsp_block,
   input  wire logic                               reset_req,
   input  wire logic                               unprotect_req,
   input  wire logic                               supply_low,
   output logic                                    busy,
   // Flash pins
   output logic [flash_host_pkg::ADDR_W-1:0]       addr_in,
   output logic [flash_host_pkg::DATA_W-1:0]       data_out,
   output logic                                    data_oe,
   input  wire logic [flash_host_pkg::DATA_W-1:0]  data_in,
   output logic                                    chip_sel_n,
   output logic                                    out_en_n,
   output logic                                    wr_en_n,
   output logic                                    reset_unprotect_n,
   output logic                                    high_identification_voltage
);
   import flash_host_pkg::*;

   localparam int AS_CYC  = ns_to_cyc(AS_NS);
   localparam int WP_CYC  = ns_to_cyc(WP_NS);
   localparam int DH_CYC  = ns_to_cyc(DH_NS);
   localparam int RD_CYC  = ns_to_cyc(RD_NS);
   localparam int GAP_CYC = ns_to_cyc(GAP_NS);
   localparam int RST_CYC = ns_to_cyc(RST_LOW_NS);
   localparam int REC_CYC = ns_to_cyc((REC_SEL_NS > REC_RDY_NS) ?
                                      REC_SEL_NS : REC_RDY_NS);
   localparam int CNT_W   = 16;

   state_t                 state;
   state_t                 next_state;
   logic [CNT_W-1:0]       cnt;
   logic [CNT_W-1:0]       next_cnt;
   logic                   is_write;
   logic                   take;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   // Writes are held off while the supply is low (see R12)
   assign req_ready = (state == ST_IDLE) && !reset_req &&
                      !(req_write && supply_low);
   assign take      = req_valid && req_ready;
   assign busy      = (state != ST_IDLE);

   always_comb begin
      next_state = state;
      next_cnt   = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
      unique case (state)
         ST_IDLE: begin
            if (reset_req && HAS_RESET_PIN) begin // see R8, see R11
               next_state = ST_RST_LOW;
               next_cnt   = CNT_W'(RST_CYC - 1);
            end else if (take && req_write) begin
               next_state = ST_WR_SETUP;
               next_cnt   = CNT_W'(AS_CYC - 1);
            end else if (take) begin
               next_state = ST_RD; // see R1
               next_cnt   = CNT_W'(RD_CYC - 1);
            end
         end
         ST_RD: begin
            if (cnt == '0) begin
               next_state = ST_GAP;
               next_cnt   = CNT_W'(GAP_CYC - 1);
            end
         end
         ST_WR_SETUP: begin
            if (cnt == '0) begin
               next_state = ST_WR_PULSE;
               next_cnt   = CNT_W'(WP_CYC - 1);
            end
         end
         ST_WR_PULSE: begin
            if (cnt == '0) begin
               next_state = ST_WR_HOLD;
               next_cnt   = CNT_W'(DH_CYC - 1);
            end
         end
         ST_WR_HOLD: begin
            if (cnt == '0) begin
               next_state = ST_GAP;
               next_cnt   = CNT_W'(GAP_CYC - 1);
            end
         end
         ST_GAP: begin
            if (cnt == '0) begin
               next_state = ST_IDLE;
            end
         end
         ST_RST_LOW: begin
            if (cnt == '0) begin
               next_state = ST_RST_REC;
               next_cnt   = CNT_W'(REC_CYC - 1);
            end
         end
         ST_RST_REC: begin
            if (cnt == '0) begin // see R9
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= HAS_RESET_PIN ? ST_RST_LOW : ST_IDLE;
         cnt   <= HAS_RESET_PIN ? CNT_W'(RST_CYC - 1) : '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins, registered from the next state

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr_in  <= '0;
         data_out <= '0;
         is_write <= 1'b0;
      end else if (take) begin
         addr_in  <= req_addr; // see R3
         data_out <= req_wdata; // see R4
         is_write <= req_write;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chip_sel_n <= 1'b1;
         out_en_n   <= 1'b1;
         wr_en_n    <= 1'b1;
         data_oe    <= 1'b0;
      end else begin
         // Idle keeps chip select high so the device ignores the bus
         chip_sel_n <= !(next_state == ST_RD ||
                         next_state == ST_WR_PULSE); // see R2
         out_en_n   <= (next_state != ST_RD); // see R18, see R19
         // Both strobes rise together; data stays driven in hold
         wr_en_n    <= (next_state != ST_WR_PULSE); // see R17
         data_oe    <= (next_state == ST_WR_SETUP ||
                        next_state == ST_WR_PULSE ||
                        next_state == ST_WR_HOLD); // see R4
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reset_unprotect_n           <= !HAS_RESET_PIN;
         high_identification_voltage <= 1'b0;
      end else begin
         reset_unprotect_n <= !(HAS_RESET_PIN &&
                                next_state == ST_RST_LOW); // see R8
         // Unprotect voltage only while the pin is not pulled low
         high_identification_voltage <= HAS_RESET_PIN && unprotect_req &&
                                        next_state != ST_RST_LOW; // see R10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         rsp_block <= '0;
      end else begin
         rsp_valid <= (state == ST_GAP) && (cnt == '0);
         if (take) begin // see R5
            rsp_block <= block_of(req_addr, TOP_BOOT); // see R6, see R21
         end
         if (state == ST_RD && cnt == '0 && !is_write) begin
            rsp_rdata <= data_in; // see R4
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [CNT_W-1:0] low_run;
   logic [CNT_W-1:0] since_rel;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         low_run   <= '0;
         // Without a reset pin the recovery is long over
         since_rel <= {CNT_W{!HAS_RESET_PIN}};
      end else begin
         low_run   <= !reset_unprotect_n ? low_run + CNT_W'(1) : '0;
         if (!reset_unprotect_n) since_rel <= '0;
         else if (since_rel != '1) since_rel <= since_rel + CNT_W'(1);
      end
   end

   sequence s_read_start;
      $fell(out_en_n);
   endsequence
   sequence s_read_done;
      ##[1:300] rsp_valid;
   endsequence
   sequence s_write_pulse;
      $fell(wr_en_n);
   endsequence

   idle_select_high_a: assert property ( // see R2
      state == ST_IDLE |-> chip_sel_n)
      else $error("chip select low while idle");
   write_oe_high_a: assert property ( // see R19
      !wr_en_n |-> out_en_n && data_oe)
      else $error("output enable low during write");
   read_we_high_a: assert property ( // see R18
      !out_en_n |-> wr_en_n && !data_oe && !chip_sel_n)
      else $error("bad strobes during read");
   addr_stable_a: assert property ( // see R3
      !chip_sel_n && $past(!chip_sel_n) |-> $stable(addr_in))
      else $error("address moved during bus cycle");
   data_hold_a: assert property ( // see R17
      $rose(wr_en_n) |-> data_oe && $stable(data_out))
      else $error("data not held at write strobe rise");
   read_resp_a: assert property ( // see R1
      s_read_start |-> s_read_done)
      else $error("read not answered in time");
   write_pulse_a: assert property ( // see R17
      s_write_pulse |-> $fell(chip_sel_n) ##1 (chip_sel_n == wr_en_n))
      else $error("write strobes not aligned");
   reset_width_a: assert property ( // see R8
      $rose(reset_unprotect_n) |-> low_run >= CNT_W'(RST_CYC))
      else $error("reset pulse too short");
   reset_recover_a: assert property ( // see R9
      !chip_sel_n |-> since_rel >= CNT_W'(REC_CYC))
      else $error("bus cycle before reset recovery");
   unprotect_pin_a: assert property ( // see R10
      high_identification_voltage |-> reset_unprotect_n)
      else $error("unprotect voltage with reset low");
   lockout_write_a: assert property ( // see R12
      supply_low |-> !(take && req_write))
      else $error("write taken under supply lockout");
   no_reset_pin_a: assert property ( // see R11
      !HAS_RESET_PIN |-> reset_unprotect_n && !high_identification_voltage)
      else $error("reset pin used in variant without it");

endmodule // flash_host

// ===== tb/flash_device_model.sv
module flash_device_model
   import flash_host_pkg::*;
(
   input  wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [flash_host_pkg::DATA_W-1:0] data_wire,
   input  wire logic                              chip_sel_n,
   input  wire logic                              out_en_n,
   input  wire logic                              wr_en_n,
   input  wire logic                              reset_unprotect_n,
   input  wire logic                              high_identification_voltage,
   input  wire logic                              supply_low,
   output logic      [flash_host_pkg::DATA_W-1:0] dev_data
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] last;
   logic              reading;
   logic              strobe;

   // Delivered erased, readable at once
   initial begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
         mem[i] = 8'hFF;
      end
      last = 8'h00;
   end

   assign reading = !chip_sel_n && !out_en_n && wr_en_n
                    && reset_unprotect_n;
   assign strobe  = !chip_sel_n && !wr_en_n;

   // Address on last falling strobe, data on first rising one
   always @(posedge strobe) begin
      wr_addr = addr_in;
   end

   // Only clears bits; top boot block protected unless high voltage
   always @(negedge strobe) begin
      if (out_en_n && reset_unprotect_n && !supply_low
          && (wr_addr < 18'h3C000 || high_identification_voltage)) begin
         mem[wr_addr] = mem[wr_addr] & data_wire;
      end
   end

   always @(*) begin
      if (reading) begin
         last = mem[addr_in];
      end
   end

   // Released lines show the inverse of the last byte driven
   assign dev_data = reading ? mem[addr_in] : ~last;
endmodule // flash_device_model

// ===== tb/test_flash_host.sv
module test_flash_host
   import flash_host_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                clk, rst_n, req_valid, req_ready, req_write;
   logic [ADDR_W-1:0]   req_addr, addr_in, a;
   logic [DATA_W-1:0]   req_wdata, rsp_rdata, data_out, data_wire, dev_data;
   logic [BLK_W-1:0]    rsp_block;
   logic                rsp_valid, reset_req, unprotect_req, supply_low, busy;
   logic                data_oe, chip_sel_n, out_en_n, wr_en_n;
   logic                reset_unprotect_n, high_identification_voltage;
   logic [BLK_W-1:0]    bot_block;
   logic                bot_reset_pin_n, bot_unprotect_hv;
   logic [15:0]         seed;
   logic [DATA_W-1:0]   shadow [logic [ADDR_W-1:0]];
   int                  n_fail, comparisons, n;
   logic [ADDR_W-1:0]   edges [17] = '{18'h3FFFF, 18'h3C000, 18'h3BFFF,
      18'h3A000, 18'h39FFF, 18'h38000, 18'h37FFF, 18'h30000, 18'h2FFFF,
      18'h10000, 18'h0FFFF, 18'h08000, 18'h06000, 18'h05FFF, 18'h04000,
      18'h03FFF, 18'h00000};

   assign data_wire = data_oe ? data_out : dev_data;

   flash_host #(.RST_LOW_NS(8), .REC_SEL_NS(8), .REC_RDY_NS(8))
   flash_host_inst (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_block(rsp_block), .reset_req(reset_req),
      .unprotect_req(unprotect_req), .supply_low(supply_low), .busy(busy),
      .addr_in(addr_in), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_wire), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
      .wr_en_n(wr_en_n), .reset_unprotect_n(reset_unprotect_n),
      .high_identification_voltage(high_identification_voltage));

   // Bottom-boot variant without reset pin shares the request side
   flash_host #(.HAS_RESET_PIN(1'b0), .TOP_BOOT(1'b0))
   flash_host_bot_inst (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_ready(), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(), .rsp_rdata(),
      .rsp_block(bot_block), .reset_req(reset_req),
      .unprotect_req(unprotect_req), .supply_low(supply_low), .busy(),
      .addr_in(), .data_out(), .data_oe(), .data_in(data_wire),
      .chip_sel_n(), .out_en_n(), .wr_en_n(),
      .reset_unprotect_n(bot_reset_pin_n),
      .high_identification_voltage(bot_unprotect_hv));

   flash_device_model flash_device_model_inst (.addr_in(addr_in),
      .data_wire(data_wire), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
      .wr_en_n(wr_en_n), .reset_unprotect_n(reset_unprotect_n),
      .high_identification_voltage(high_identification_voltage),
      .supply_low(supply_low), .dev_data(dev_data));

   ////////////////////////////////////////////////////////////////////////
   function automatic int cyc(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [BLK_W-1:0] exp_blk(input logic [ADDR_W-1:0] x);
      if (x >= 18'h3C000) return 3'h6;
      if (x >= 18'h3A000) return 3'h5;
      if (x >= 18'h38000) return 3'h4;
      if (x >= 18'h30000) return 3'h3;
      return {1'b0, x[17:16]};
   endfunction

   function automatic logic [BLK_W-1:0] exp_bot(input logic [ADDR_W-1:0] x);
      if (x >= 18'h10000) return {1'b0, x[17:16]} + 3'h3;
      if (x >= 18'h08000) return 3'h3;
      if (x >= 18'h06000) return 3'h2;
      if (x >= 18'h04000) return 3'h1;
      return 3'h0;
   endfunction

   function automatic logic [DATA_W-1:0] expb(input logic [ADDR_W-1:0] x);
      return shadow.exists(x) ? shadow[x] : 8'hFF;
   endfunction

   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %0h expected %0h",
                  $time, seen, exp);
      end
   endtask

   task automatic access(input logic wr, input logic [ADDR_W-1:0] x,
                         input logic [DATA_W-1:0] d);
      int k;
      @(negedge clk);
      req_write = wr;
      req_addr = x;
      req_wdata = d;
      req_valid = 1'b1;
      k = 0;
      while (req_ready !== 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      check(18'(busy), 18'h1);
      k = 0;
      while (rsp_valid !== 1'b1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      check(18'(busy), 18'h0);
      check(18'(k), 18'(wr ? cyc(T_AS_NS) + cyc(T_WP_NS) + cyc(T_DH_NS)
         + cyc(T_GAP_NS) : cyc(T_RD_NS) + cyc(T_GAP_NS)));
      check(18'(rsp_block), 18'(exp_blk(x)));
      check(18'(bot_block), 18'(exp_bot(x)));
      if (wr && (x < 18'h3C000 || unprotect_req)) shadow[x] = expb(x) & d;
      if (!wr) check(18'(rsp_rdata), 18'(expb(x)));
   endtask

   task automatic complete_run;
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run;
   end

   // Wire checks on every cycle
   always @(negedge clk) begin
      if (rst_n && !wr_en_n) check(18'(out_en_n), 18'h1);
      if (rst_n && !reset_unprotect_n) begin
         check(18'(chip_sel_n), 18'h1);
      end
      if (rst_n) begin
         check(18'({bot_reset_pin_n, bot_unprotect_hv}), 18'h2);
      end
   end

   initial begin
      {rst_n, req_valid, req_write, reset_req, unprotect_req} = 5'h00;
      {req_addr, req_wdata, supply_low} = 27'h0000000;
      {n_fail, comparisons} = 64'h0;
      seed = 16'h002E;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      foreach (edges[i]) begin
         access(1'b0, edges[i], 8'h00);
      end
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         a = {seed[3:2], seed};
         seed = lfsr(seed);
         access(1'b1, a, seed[7:0]);
         access(1'b0, a, 8'h00);
      end
      access(1'b1, 18'h3C010, 8'h0F);
      access(1'b0, 18'h3C010, 8'h00);
      unprotect_req = 1'b1;
      repeat (4) @(negedge clk);
      check(18'(high_identification_voltage), 18'h1);
      access(1'b1, 18'h3C010, 8'h0F);
      access(1'b0, 18'h3C010, 8'h00);
      unprotect_req = 1'b0;
      supply_low = 1'b1;
      req_addr = 18'h00100;
      req_write = 1'b1;
      req_valid = 1'b1;
      repeat (3) begin
         @(negedge clk);
         check(18'(req_ready), 18'h0);
      end
      req_valid = 1'b0;
      access(1'b0, 18'h00100, 8'h00);
      supply_low = 1'b0;
      reset_req = 1'b1;
      n = 0;
      while (reset_unprotect_n !== 1'b0 && n < 50) begin
         @(negedge clk);
         n++;
      end
      reset_req = 1'b0;
      n = 0;
      while (reset_unprotect_n === 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      check(18'(n >= cyc(8)), 18'h1);
      access(1'b0, a, 8'h00);
      complete_run;
   end
endmodule // test_flash_host
